/* trigger_unit_control_regs.sv */
// Control, enable and flag registers of a two-generator trigger unit, reached over APB.
// Assumes synchronous inputs on core_clk; generator events arrive as one-cycle pulses.
`include "trigger_unit_map.svh"
`timescale 1ns/100ps
`default_nettype none

module trigger_unit_control_regs (
  input  wire logic                      core_clk,
  input  wire logic                      srst,
  input  wire logic                      clk_en,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [7:0]                paddr,
  input  wire logic [31:0]               pwdata,
  output logic                           pready,
  output logic      [31:0]               prdata,
  output logic                           pslverr,
  input  wire logic                      freeze_mode,
  input  wire logic                      reload_event,
  input  wire logic                      reload_forced,
  input  wire logic [1:0]                gen_end_of_list,
  input  wire logic [1:0]                gen_max_reached,
  input  wire logic [1:0]                gen_access_err,
  input  wire logic [1:0]                gen_reload_err,
  input  wire logic [1:0]                gen_timing_err,
  input  wire logic                      double_bit_err,
  output logic                           time_base_run,
  output logic      [1:0]                gen_run,
  output logic      [1:0]                gen_list_sel,
  output logic                           glb_load_okay,
  output logic                           irq
);
  import trigger_unit_pkg::*;

  reg_byte_t  enable_reg;
  logic       load_okay_reg;
  logic       ovr_ie_reg;
  reg_byte_t  gen_ie_reg;
  logic       ovr_flag_reg;
  logic       dbe_flag_reg;
  reg_byte_t  gen_flag_reg;
  logic [1:0] list_reg;
  logic       pready_reg;
  logic [31:0] prdata_reg;
  logic       pslverr_reg;
  logic       tb_run_reg;
  logic [1:0] gen_run_reg;
  logic       irq_reg;
  apb_phase_t phase_reg;
  apb_phase_t phase_next;

  // Address decode
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  // Write-one-to-clear, set wins
  function automatic logic w1c(input logic flag, input logic set, input logic clr);
    w1c = set || (flag && !clr);
  endfunction : w1c

  // Bus phase tracker; answer state matches pready
  always_comb begin
    phase_next = phase_reg;
    case (phase_reg)
      ACC_IDLE: begin
        if (psel && penable) begin
          phase_next = ACC_ACCESS;
        end else if (psel) begin
          phase_next = ACC_SETUP;
        end
      end
      ACC_SETUP: begin
        if (psel && penable) begin
          phase_next = ACC_ACCESS;
        end else if (!psel) begin
          phase_next = ACC_IDLE;
        end
      end
      ACC_ACCESS: begin
        if (psel && !penable) begin
          phase_next = ACC_SETUP;
        end else begin
          phase_next = ACC_IDLE;
        end
      end
      default: begin
        phase_next = ACC_IDLE;
      end
    endcase
  end

  // Writes land at the completing edge
  wire logic acc      = psel && penable && (phase_reg != ACC_ACCESS);
  wire logic wr       = psel && penable && pready_reg && pwrite;
  wire logic rd       = acc && !pwrite;
  wire logic sel_en   = hit(paddr, `TU_OFF_ENABLE);
  wire logic sel_lc   = hit(paddr, `TU_OFF_LOAD_CTRL);
  wire logic sel_oie  = hit(paddr, `TU_OFF_OVR_IE);
  wire logic sel_gie  = hit(paddr, `TU_OFF_GEN_IE);
  wire logic sel_fh   = hit(paddr, `TU_OFF_FLAG_HI);
  wire logic sel_fl   = hit(paddr, `TU_OFF_FLAG_LO);
  wire logic mapped   = sel_en || sel_lc || sel_oie || sel_gie || sel_fh || sel_fl;

  wire logic gen0_enable = enable_reg[`TU_BIT_GEN0_EN];
  wire logic gen1_enable = enable_reg[`TU_BIT_GEN1_EN];
  wire logic freeze_counter_stop = enable_reg[`TU_BIT_FRZ_STOP];

  // Load-okay write qualification
  wire logic lc_wr      = wr && sel_lc;
  wire logic lc_wr_one  = lc_wr && pwdata[`TU_BIT_LOAD_OKAY];
  wire logic lc_wr_zero = lc_wr && !pwdata[`TU_BIT_LOAD_OKAY] && !gen0_enable && !gen1_enable;
  wire logic load_okay_next = lc_wr_one ? 1'b1 :
                              (reload_event || lc_wr_zero) ? 1'b0 : load_okay_reg;

  // Reload overrun detection
  wire logic overrun_evt = reload_event && !load_okay_reg && !reload_forced;
  wire logic [1:0] list_next = (reload_event && load_okay_reg) ? ~list_reg : list_reg;

  // Generator flag events, bit order matches the generator interrupt enable register
  wire logic [1:0] done_evt = gen_end_of_list | gen_max_reached;
  wire logic [1:0] rerr_evt = gen_reload_err & {2{!reload_forced}};
  wire reg_byte_t gen_evt = {gen_access_err[1], rerr_evt[1], gen_timing_err[1], done_evt[1],
                             gen_access_err[0], rerr_evt[0], gen_timing_err[0], done_evt[0]};
  wire reg_byte_t gen_clr = (wr && sel_fl) ? pwdata[7:0] : 8'h00;
  wire logic fh_wr = wr && sel_fh;

  // Flag set wins over clear
  wire reg_byte_t gen_flag_next = gen_evt | (gen_flag_reg & ~gen_clr);
  wire logic ovr_flag_next = w1c(ovr_flag_reg, overrun_evt, fh_wr && pwdata[`TU_BIT_OVR_FLAG]);
  wire logic dbe_flag_next = w1c(dbe_flag_reg, double_bit_err, fh_wr && pwdata[`TU_BIT_DBE_FLAG]);

  // Interrupt request
  wire reg_byte_t gen_masked = gen_flag_next & gen_ie_reg;
  wire logic irq_next = (|gen_masked) || (ovr_flag_next && ovr_ie_reg);

  // Run controls
  wire logic tb_run_next = !(freeze_counter_stop && freeze_mode);
  wire logic [1:0] gen_run_next = {gen1_enable, gen0_enable} & {2{!dbe_flag_next}};

  // Register write values
  wire reg_byte_t enable_next = (wr && sel_en) ? (pwdata[7:0] & `TU_ENABLE_MASK) : enable_reg;
  wire logic ovr_ie_next = (wr && sel_oie) ? pwdata[`TU_BIT_OVR_IE] : ovr_ie_reg;
  wire reg_byte_t gen_ie_next = (wr && sel_gie) ? pwdata[7:0] : gen_ie_reg;
  wire logic pready_next = acc;
  wire logic pslverr_next = acc && !mapped;

  // Read mux, unused bits zero
  reg_byte_t rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    if (sel_en) begin
      rd_byte = enable_reg;
    end else if (sel_lc) begin
      rd_byte = {7'h00, load_okay_reg};
    end else if (sel_oie) begin
      rd_byte = {7'h00, ovr_ie_reg};
    end else if (sel_gie) begin
      rd_byte = gen_ie_reg;
    end else if (sel_fh) begin
      rd_byte = {6'h00, dbe_flag_reg, ovr_flag_reg};
    end else if (sel_fl) begin
      rd_byte = gen_flag_reg;
    end
  end

  wire logic [31:0] prdata_next = rd ? {24'h00_0000, rd_byte} : 32'h0000_0000;

  // Enable register
  always_ff @(posedge core_clk) begin
    if (srst) begin
      enable_reg <= `TU_RESET_BYTE;
    end else if (clk_en) begin
      enable_reg <= enable_next;
    end
  end

  // Overrun interrupt enable
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ovr_ie_reg <= 1'b0;
    end else if (clk_en) begin
      ovr_ie_reg <= ovr_ie_next;
    end
  end

  // Generator interrupt enables
  always_ff @(posedge core_clk) begin
    if (srst) begin
      gen_ie_reg <= `TU_RESET_BYTE;
    end else if (clk_en) begin
      gen_ie_reg <= gen_ie_next;
    end
  end

  // Load-okay bit
  always_ff @(posedge core_clk) begin
    if (srst) begin
      load_okay_reg <= 1'b0;
    end else if (clk_en) begin
      load_okay_reg <= load_okay_next;
    end
  end

  // Reload overrun flag
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ovr_flag_reg <= 1'b0;
    end else if (clk_en) begin
      ovr_flag_reg <= ovr_flag_next;
    end
  end

  // Double-bit error flag
  always_ff @(posedge core_clk) begin
    if (srst) begin
      dbe_flag_reg <= 1'b0;
    end else if (clk_en) begin
      dbe_flag_reg <= dbe_flag_next;
    end
  end

  // Generator flags, one bit each
  for (genvar g = 0; g < 8; g++) begin : g_flag
    always_ff @(posedge core_clk) begin
      if (srst) begin
        gen_flag_reg[g] <= 1'b0;
      end else if (clk_en) begin
        gen_flag_reg[g] <= gen_flag_next[g];
      end
    end
  end

  // List in use per generator
  always_ff @(posedge core_clk) begin
    if (srst) begin
      list_reg <= 2'b00;
    end else if (clk_en) begin
      list_reg <= list_next;
    end
  end

  // Bus phase
  always_ff @(posedge core_clk) begin
    if (srst) begin
      phase_reg <= ACC_IDLE;
    end else if (clk_en) begin
      phase_reg <= phase_next;
    end
  end

  // Bus answer
  always_ff @(posedge core_clk) begin
    if (srst) begin
      pready_reg <= 1'b0;
    end else if (clk_en) begin
      pready_reg <= pready_next;
    end
  end

  // Bus error
  always_ff @(posedge core_clk) begin
    if (srst) begin
      pslverr_reg <= 1'b0;
    end else if (clk_en) begin
      pslverr_reg <= pslverr_next;
    end
  end

  // Read data
  always_ff @(posedge core_clk) begin
    if (srst) begin
      prdata_reg <= 32'h0000_0000;
    end else if (clk_en) begin
      prdata_reg <= prdata_next;
    end
  end

  // Time base run
  always_ff @(posedge core_clk) begin
    if (srst) begin
      tb_run_reg <= 1'b1;
    end else if (clk_en) begin
      tb_run_reg <= tb_run_next;
    end
  end

  // Generator run
  always_ff @(posedge core_clk) begin
    if (srst) begin
      gen_run_reg <= 2'b00;
    end else if (clk_en) begin
      gen_run_reg <= gen_run_next;
    end
  end

  // Interrupt request
  always_ff @(posedge core_clk) begin
    if (srst) begin
      irq_reg <= 1'b0;
    end else if (clk_en) begin
      irq_reg <= irq_next;
    end
  end

  assign pready        = pready_reg;
  assign prdata        = prdata_reg;
  assign pslverr       = pslverr_reg;
  assign time_base_run = tb_run_reg;
  assign gen_run       = gen_run_reg;
  assign gen_list_sel  = list_reg;
  assign glb_load_okay = load_okay_reg;
  assign irq           = irq_reg;

endmodule : trigger_unit_control_regs

`default_nettype wire

/* trigger_unit_map.svh */
// Register offsets, field positions and reset values of the trigger unit control bank.
// Assumes APB byte addressing with one aligned 32-bit word per register.
`ifndef TRIGGER_UNIT_MAP_SVH
`define TRIGGER_UNIT_MAP_SVH

// Register indices; the bus byte address is four times the index
`define TU_IDX_ENABLE      0
`define TU_IDX_LOAD_CTRL   1
`define TU_IDX_OVR_IE      2
`define TU_IDX_GEN_IE      3
`define TU_IDX_FLAG_HI     4
`define TU_IDX_FLAG_LO     5

`define TU_OFF_ENABLE      8'h00
`define TU_OFF_LOAD_CTRL   8'h04
`define TU_OFF_OVR_IE      8'h08
`define TU_OFF_GEN_IE      8'h0c
`define TU_OFF_FLAG_HI     8'h10
`define TU_OFF_FLAG_LO     8'h14

`define TU_BIT_FRZ_STOP    6
`define TU_BIT_GEN1_EN     1
`define TU_BIT_GEN0_EN     0
`define TU_BIT_LOAD_OKAY   0
`define TU_BIT_OVR_IE      0
`define TU_BIT_DBE_FLAG    1
`define TU_BIT_OVR_FLAG    0

`define TU_ENABLE_MASK     8'h43
`define TU_RESET_BYTE      8'h00

`endif

/* trigger_unit_pkg.sv */
// Types shared by the trigger unit control bank.
// Assumes the constants header is included by the design file.
package trigger_unit_pkg;
  typedef logic [7:0] reg_byte_t;
  typedef enum logic [1:0] {
    ACC_IDLE   = 2'b00,
    ACC_SETUP  = 2'b01,
    ACC_ACCESS = 2'b10
  } apb_phase_t;
endpackage : trigger_unit_pkg

/* trigger_unit_control_regs_assertions.sv */
// Assertions on the trigger unit control bank ports.
// Assumes clk_en held high by the surroundings.
`timescale 1ns/100ps
`default_nettype none
module trigger_unit_control_regs_assertions (
  input wire logic        core_clk,
  input wire logic        srst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        freeze_mode,
  input wire logic        reload_event,
  input wire logic        double_bit_err,
  input wire logic        time_base_run,
  input wire logic [1:0]  gen_run,
  input wire logic [1:0]  gen_list_sel,
  input wire logic        glb_load_okay
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  // First access cycle
  sequence acc_start;
    psel && penable && !pready;
  endsequence
  sequence swap_req;
    reload_event && glb_load_okay;
  endsequence
  AST_RDHI: assert property (prdata[31:8] == 24'h0) else $error("high read bits set");
  AST_ANS: assert property (acc_start |=> pready) else $error("no answer");
  AST_ONE: assert property (pready |=> !pready) else $error("answer too long");
  AST_RUN: assert property (!freeze_mode |=> time_base_run) else $error("time base stopped");
  AST_DBE: assert property (double_bit_err |=> gen_run == 2'b00) else $error("generators run");
  AST_SWAP: assert property (swap_req |=> gen_list_sel == ~$past(gen_list_sel)) else $error("no swap");
  AST_KEEP: assert property (reload_event && !glb_load_okay |=> $stable(gen_list_sel)) else $error("swap");
  AST_CLR: assert property (reload_event && !(psel && pwrite) |=> !glb_load_okay) else $error("kept");
endmodule : trigger_unit_control_regs_assertions
bind trigger_unit_control_regs trigger_unit_control_regs_assertions i_trigger_unit_control_regs_assertions (
  .core_clk, .srst, .psel, .penable, .pwrite, .pready, .prdata, .freeze_mode, .reload_event,
  .double_bit_err, .time_base_run, .gen_run, .gen_list_sel, .glb_load_okay);
`default_nettype wire

/* trigger_unit_control_regs_tb_top.sv */
// Self-checking bench for the trigger unit control bank.
// Assumes the map header; clk_en held high.
`include "trigger_unit_map.svh"
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin fails++; $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module trigger_unit_control_regs_tb_top;
  logic        core_clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, freeze_mode = 0, reload_forced = 0;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [11:0] evs = 0;
  logic [1:0]  gen_run, gen_list_sel;
  logic        pready, pslverr, time_base_run, glb_load_okay, irq, err;
  int          fails = 0, checks_done = 0, cyc = 0;
  always #5 core_clk = ~core_clk;
  trigger_unit_control_regs i_trigger_unit_control_regs (.core_clk, .srst, .clk_en(1'b1), .psel, .penable,
    .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .freeze_mode, .reload_event(evs[8]), .reload_forced,
    .gen_end_of_list({evs[4], evs[0]}), .gen_max_reached(evs[11:10]), .gen_access_err({evs[7], evs[3]}),
    .gen_reload_err({evs[6], evs[2]}), .gen_timing_err({evs[5], evs[1]}), .double_bit_err(evs[9]),
    .time_base_run, .gen_run, .gen_list_sel, .glb_load_okay, .irq);
  task automatic conclude;
    if (fails == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : conclude
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask : xfer
  task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    `CHK("read data", e, rd)
  endtask : chk_rd
  task automatic pulse(input logic [11:0] v);
    evs <= v;
    @(posedge core_clk);
    evs <= 12'h000;
    repeat (2) @(posedge core_clk);
  endtask : pulse
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fails++;
      conclude();
    end
  end
  initial begin
    repeat (16) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    for (int a = 0; a < 24; a += 4) chk_rd(8'(a), 32'h0);
    xfer(1'b0, 8'h18, 32'h0);
    `CHK("unmapped error", 1'b1, err)
    xfer(1'b1, `TU_OFF_ENABLE, 32'hff);
    chk_rd(`TU_OFF_ENABLE, {24'h0, `TU_ENABLE_MASK});
    `CHK("generators", 2'b11, gen_run)
    xfer(1'b1, `TU_OFF_ENABLE, 32'h42);
    `CHK("generators", 2'b10, gen_run)
    freeze_mode <= 1'b1;
    repeat (2) @(posedge core_clk);
    `CHK("time base", 1'b0, time_base_run)
    freeze_mode <= 1'b0;
    xfer(1'b1, `TU_OFF_LOAD_CTRL, 32'h1);
    `CHK("global load okay", 1'b1, glb_load_okay)
    xfer(1'b1, `TU_OFF_LOAD_CTRL, 32'h0);
    chk_rd(`TU_OFF_LOAD_CTRL, 32'h1);
    pulse(12'h100);
    `CHK("list select", 2'b11, gen_list_sel)
    `CHK("global load okay", 1'b0, glb_load_okay)
    pulse(12'h100);
    `CHK("list select", 2'b11, gen_list_sel)
    chk_rd(`TU_OFF_FLAG_HI, 32'h1);
    `CHK("request", 1'b0, irq)
    xfer(1'b1, `TU_OFF_OVR_IE, 32'h1);
    `CHK("request", 1'b1, irq)
    xfer(1'b1, `TU_OFF_FLAG_HI, 32'h1);
    `CHK("request", 1'b0, irq)
    reload_forced <= 1'b1;
    pulse(12'h100);
    reload_forced <= 1'b0;
    chk_rd(`TU_OFF_FLAG_HI, 32'h0);
    for (int i = 0; i < 8; i++) begin
      pulse(12'(1 << i));
      chk_rd(`TU_OFF_FLAG_LO, 32'(1 << i));
      `CHK("request", 1'b0, irq)
      xfer(1'b1, `TU_OFF_GEN_IE, 32'(1 << i));
      `CHK("request", 1'b1, irq)
      xfer(1'b1, `TU_OFF_FLAG_LO, 32'hff);
    end
    pulse(12'hc00);
    chk_rd(`TU_OFF_FLAG_LO, 32'h11);
    pulse(12'h200);
    `CHK("generators", 2'b00, gen_run)
    xfer(1'b1, `TU_OFF_LOAD_CTRL, 32'h1);
    xfer(1'b1, `TU_OFF_ENABLE, 32'h0);
    xfer(1'b1, `TU_OFF_LOAD_CTRL, 32'h0);
    chk_rd(`TU_OFF_LOAD_CTRL, 32'h0);
    conclude();
  end
endmodule : trigger_unit_control_regs_tb_top
`default_nettype wire
